// >>> core/adc_capture_pkg.sv
// constants and carrier types for the four-channel serial converter capture block
package adc_capture_pkg;

  // clock rates and frame rate
  localparam int LOGIC_CLK_MHZ = 50;
  localparam int BIT_CLK_MHZ = 100;
  localparam int SAMPLE_RATE_MHZ = 5;
  localparam int LOGIC_PERIOD_NS = 20;

  // logic cycles per conversion frame
  localparam int FRAME_CYC = LOGIC_CLK_MHZ / SAMPLE_RATE_MHZ;
  // convert pulse high time in logic cycles
  localparam int CNV_HIGH_CYC = 2;

  // least time from convert rise to first bit clock rise, rounded up to cycles
  localparam int CNV_TO_CLK_NS = 145;
  localparam int CNV_TO_CLK_CYC = (CNV_TO_CLK_NS + LOGIC_PERIOD_NS - 1) / LOGIC_PERIOD_NS;
  // longest time from next convert rise to last bit clock fall
  localparam int BURST_END_NS = 110;
  localparam int BURST_END_CYC = BURST_END_NS / LOGIC_PERIOD_NS;

  // the gate is delayed by the resync stages before it reaches the clock
  localparam int SYNC_LAT_CYC = 2;
  localparam int GATE_ON_CYC = CNV_TO_CLK_CYC - SYNC_LAT_CYC;

  // serial word layout
  localparam int NUM_ADC = 4;
  localparam int WORD_W = 16;
  localparam int SHIFT_CNT_W = 5;
  // logic cycles for which the gate stays open to pass one word
  localparam int GATE_LEN_CYC = WORD_W * LOGIC_CLK_MHZ / BIT_CLK_MHZ;

  // reset values
  localparam logic [1:0] DET_RESET = 2'h3;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // one parallel word per converter
  typedef struct packed {
    logic [NUM_ADC-1:0][WORD_W-1:0] word;
  } samples_type;

endpackage

// >>> core/signal_sync.sv
// two-flop level synchroniser with asynchronous clear
`timescale 1ns/100ps
module signal_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_clear_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage is read by the second stage only
  always_comb begin
    meta_next = i_d;
    sync_next = meta_reg;
  end

  // both stages clear to zero
  always_ff @(posedge i_clk or negedge i_clear_n) begin
    if (!i_clear_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_q = sync_reg;

endmodule // signal_sync

// >>> core/rx_ping_pong.sv
// ping-pong pair of receive shift registers for one converter
`timescale 1ns/100ps
module rx_ping_pong (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_shift,
  input wire logic i_bank,
  input wire logic i_data,
  output logic [adc_capture_pkg::WORD_W-1:0] o_word
);

  logic [adc_capture_pkg::WORD_W-1:0] bank0_reg;
  logic [adc_capture_pkg::WORD_W-1:0] bank0_next;
  logic [adc_capture_pkg::WORD_W-1:0] bank1_reg;
  logic [adc_capture_pkg::WORD_W-1:0] bank1_next;
  logic [adc_capture_pkg::WORD_W-1:0] word_reg;
  logic [adc_capture_pkg::WORD_W-1:0] word_next;

  // selected bank shifts msb first, the other one holds the last word
  always_comb begin
    bank0_next = bank0_reg;
    bank1_next = bank1_reg;
    if (i_shift && !i_bank) begin
      bank0_next = {bank0_reg[adc_capture_pkg::WORD_W-2:0], i_data}; // RL9 RL16
    end else if (i_shift && i_bank) begin
      bank1_next = {bank1_reg[adc_capture_pkg::WORD_W-2:0], i_data}; // RL9 RL16
    end
    word_next = i_bank ? bank0_reg : bank1_reg; // RL12
  end

  // registers of the pair and the presented word
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bank0_reg <= adc_capture_pkg::WORD_RESET;
      bank1_reg <= adc_capture_pkg::WORD_RESET;
      word_reg <= adc_capture_pkg::WORD_RESET;
    end else begin
      bank0_reg <= bank0_next;
      bank1_reg <= bank1_next;
      word_reg <= word_next;
    end
  end

  assign o_word = word_reg;

  // new bit lands in the low end of the bank that was receiving
  shift_order_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL16
    i_shift |=> ($past(i_bank) ? bank1_reg[0] : bank0_reg[0]) == $past(i_data))
    else $error("serial bit not shifted in at lsb end");

  // bank1_reg does not move while bank0 shifts
  hold_bank_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL9
    (i_shift && !i_bank) |=> $stable(bank1_reg))
    else $error("holding register changed during capture");

endmodule // rx_ping_pong

// >>> core/adc_serial_capture.sv
// convert and bit clock generation with ping-pong serial capture for four converters
// Operation
// RL1: convert and read out at 5 MHz
// RL2: convert pulse mid-way through previous readout
// RL3: bit clock runs at 100 MHz
// RL4: logic-domain gate, resynced to 100 MHz domain
// RL5: at least 145 ns convert to clock
// RL6: last clock fall within 110 ns
// RL7: converters convert and shift on clock
// RL8: shared convert and clock, per-converter pairs
// RL9: one register captures, other holds word
// RL10: full capture register swaps roles
// RL11: 5-bit counter, low bits count 16
// RL12: counter msb selects capture register
// RL13: 2-bit detector, cleared while clock high
// RL14: strobe when detector survives one edge
// RL15: samples are 16-bit words
// RL16: bits shifted in msb first
`timescale 1ns/100ps
module adc_serial_capture (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pll_clk,
  input wire logic [adc_capture_pkg::NUM_ADC-1:0] i_adc_data,
  output logic o_convert_pulse,
  output logic o_bit_clk,
  output logic o_new_data,
  output adc_capture_pkg::samples_type o_samples
);

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } frame_state_type;

  localparam logic [3:0] FRAME_LAST = 4'(adc_capture_pkg::FRAME_CYC - 1);
  localparam logic [3:0] CNV_HIGH = 4'(adc_capture_pkg::CNV_HIGH_CYC);
  localparam logic [3:0] GATE_ON = 4'(adc_capture_pkg::GATE_ON_CYC);
  localparam logic [3:0] GATE_LEN = 4'(adc_capture_pkg::GATE_LEN_CYC);
  localparam logic [3:0] WORD_LAST = 4'(adc_capture_pkg::WORD_W - 1);

  // reset copies for each domain
  logic rst_n;
  logic link_rst_n;

  // logic domain frame state
  frame_state_type state_reg;
  frame_state_type state_next;
  logic [3:0] frame_cnt_reg;
  logic [3:0] frame_cnt_next;
  logic [3:0] gate_left_reg;
  logic [3:0] gate_left_next;
  logic gate_reg;
  logic gate_next;
  logic cnv_reg;
  logic cnv_next;

  // link domain gate and shift control
  logic gate_link;
  logic gate_neg_reg;
  logic gate_neg_next;
  logic bit_clk_gated;
  logic [adc_capture_pkg::SHIFT_CNT_W-1:0] shift_cnt_reg;
  logic [adc_capture_pkg::SHIFT_CNT_W-1:0] shift_cnt_next;
  logic shift_en;
  logic bank_sel;

  // end of burst detection and output capture
  logic [1:0] det_reg;
  logic [1:0] det_next;
  logic strobe_reg;
  logic strobe_next;
  adc_capture_pkg::samples_type samples_reg;
  adc_capture_pkg::samples_type samples_next;
  adc_capture_pkg::samples_type rx_words;

  // logic domain reset released through two flops
  signal_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .i_clk(i_clk),
    .i_clear_n(i_reset_n),
    .i_d(1'b1),
    .o_q(rst_n)
  );

  // link domain reset released on the pll clock
  signal_sync #(
    .WIDTH(1)
  ) u_link_rst_sync (
    .i_clk(i_pll_clk),
    .i_clear_n(i_reset_n),
    .i_d(1'b1),
    .o_q(link_rst_n)
  );

  // frame timer: convert at count 0, gate opens at a fixed offset
  always_comb begin
    state_next = state_reg;
    frame_cnt_next = frame_cnt_reg;
    gate_left_next = gate_left_reg;
    case (state_reg)
      ST_IDLE: begin
        state_next = ST_RUN;
        frame_cnt_next = 4'h0;
      end
      ST_RUN: begin
        if (frame_cnt_reg == FRAME_LAST) begin
          frame_cnt_next = 4'h0; // RL1
        end else begin
          frame_cnt_next = frame_cnt_reg + 4'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (state_next == ST_RUN && frame_cnt_next == GATE_ON) begin
      gate_left_next = GATE_LEN; // RL4 RL5
    end else if (gate_left_reg != 4'h0) begin
      gate_left_next = gate_left_reg - 4'h1;
    end
    gate_next = gate_left_next != 4'h0; // RL6
    cnv_next = (state_next == ST_RUN) && (frame_cnt_next < CNV_HIGH); // RL1 RL2
  end

  // frame timer registers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      frame_cnt_reg <= 4'h0;
      gate_left_reg <= 4'h0;
      gate_reg <= 1'b0;
      cnv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      frame_cnt_reg <= frame_cnt_next;
      gate_left_reg <= gate_left_next;
      gate_reg <= gate_next;
      cnv_reg <= cnv_next;
    end
  end

  // gate resynchronised into the pll domain
  signal_sync #(
    .WIDTH(1)
  ) u_gate_sync (
    .i_clk(i_pll_clk),
    .i_clear_n(link_rst_n),
    .i_d(gate_reg),
    .o_q(gate_link)
  );

  // gate retimed on the falling edge so the clock never gets a runt pulse
  always_comb begin
    gate_neg_next = gate_link; // RL4
  end

  always_ff @(negedge i_pll_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      gate_neg_reg <= 1'b0;
    end else begin
      gate_neg_reg <= gate_neg_next;
    end
  end

  // one gated clock shared by all converters
  assign bit_clk_gated = i_pll_clk & gate_neg_reg; // RL3 RL8

  // shift counter: low bits count bits, msb picks the capturing register
  always_comb begin
    shift_cnt_next = shift_cnt_reg;
    if (shift_en) begin
      shift_cnt_next = shift_cnt_reg + 5'h01; // RL11 RL10
    end
  end

  always_ff @(posedge i_pll_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_cnt_reg <= 5'h00;
    end else begin
      shift_cnt_reg <= shift_cnt_next;
    end
  end

  assign shift_en = gate_neg_reg;
  assign bank_sel = shift_cnt_reg[adc_capture_pkg::SHIFT_CNT_W-1]; // RL12

  // one receive pair per converter
  genvar ch;
  generate
    for (ch = 0; ch < adc_capture_pkg::NUM_ADC; ch++) begin : g_rx
      rx_ping_pong u_rx (
        .i_clk(i_pll_clk),
        .i_reset_n(link_rst_n),
        .i_shift(shift_en),
        .i_bank(bank_sel),
        .i_data(i_adc_data[ch]),
        .o_word(rx_words.word[ch]) // RL8 RL15
      );
    end
  endgenerate

  // detector counts logic edges and saturates
  always_comb begin
    det_next = det_reg;
    if (det_reg != 2'h3) begin
      det_next = det_reg + 2'h1; // RL13
    end
  end

  // cleared asynchronously whenever the gated clock is high
  always_ff @(posedge i_clk or posedge bit_clk_gated or negedge rst_n) begin
    if (!rst_n) begin
      det_reg <= adc_capture_pkg::DET_RESET;
    end else if (bit_clk_gated) begin
      det_reg <= 2'h0; // RL13
    end else begin
      det_reg <= det_next;
    end
  end

  // strobe and word capture; words are quiet in the link domain after the burst
  always_comb begin
    strobe_next = det_reg == 2'h1; // RL14
    samples_next = samples_reg;
    if (strobe_next) begin
      samples_next = rx_words; // RL14 RL15
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_reg <= 1'b0;
      samples_reg <= '0;
    end else begin
      strobe_reg <= strobe_next;
      samples_reg <= samples_next;
    end
  end

  // outputs
  assign o_convert_pulse = cnv_reg;
  assign o_bit_clk = bit_clk_gated;
  assign o_new_data = strobe_reg;
  assign o_samples = samples_reg;

  // gate burst shape in logic cycles
  sequence gate_burst_s;
    gate_reg [*8] ##1 !gate_reg;
  endsequence

  sequence cnv_pulse_s;
    o_convert_pulse [*2] ##1 !o_convert_pulse;
  endsequence

  // frames repeat every ten logic cycles
  frame_rate_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL1
    $rose(o_convert_pulse) |-> ##10 $rose(o_convert_pulse))
    else $error("convert pulse period is not ten cycles");

  // convert pulse has a fixed width
  cnv_width_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL8
    $rose(o_convert_pulse) |-> cnv_pulse_s)
    else $error("convert pulse width wrong");

  // gate opens six cycles after convert rises
  gate_delay_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL5
    $rose(o_convert_pulse) |-> ##4 !gate_reg [*2] ##1 gate_reg)
    else $error("gate opened at wrong offset from convert");

  // gate stays open for exactly one word
  gate_length_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL4
    $rose(gate_reg) |-> gate_burst_s)
    else $error("gate burst length wrong");

  // next convert lands half way through the burst
  cnv_midway_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL2
    $rose(gate_reg) |-> ##4 ($rose(o_convert_pulse) && gate_reg))
    else $error("convert not issued mid readout");

  // burst closes within the allowed time after the next convert
  burst_end_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL6
    $rose(o_convert_pulse) && gate_reg |-> ##[1:4] !gate_reg)
    else $error("gate still open too long after convert");

  // every shift count of sixteen flips the capturing register
  bank_swap_a: assert property (@(posedge i_pll_clk) disable iff (!link_rst_n) // RL10
    (shift_en && shift_cnt_reg[3:0] == WORD_LAST) |=> bank_sel != $past(bank_sel))
    else $error("registers did not swap after a full word");

  // counter moves only while clocking bits
  shift_hold_a: assert property (@(posedge i_pll_clk) disable iff (!link_rst_n) // RL11
    !shift_en |=> $stable(shift_cnt_reg))
    else $error("shift counter moved without bit clock");

  // one burst yields sixteen shifts
  burst_bits_a: assert property (@(posedge i_pll_clk) disable iff (!link_rst_n) // RL11
    $rose(shift_en) |-> shift_en [*8] ##1 shift_en [*8] ##1 !shift_en)
    else $error("burst did not carry sixteen bits");

  // strobe follows the end of each burst
  strobe_after_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL14
    $fell(gate_reg) |-> ##[2:8] o_new_data)
    else $error("no data strobe after burst end");

  // strobe is a single cycle pulse
  strobe_pulse_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL14
    o_new_data |=> !o_new_data)
    else $error("data strobe longer than one cycle");

  // no strobe while the bit clock is still running
  strobe_quiet_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RL13
    gate_reg && $past(gate_reg) && $past(gate_reg, 2) |-> !o_new_data)
    else $error("data strobe during burst");

endmodule // adc_serial_capture

// >>> bench/adc_chip_model.sv
// behavioural model of the four serial-output converters on the capture link
`timescale 1ns/100ps
module adc_chip_model (
  input wire logic i_convert_pulse,
  input wire logic i_bit_clk,
  input wire adc_capture_pkg::samples_type i_words,
  output logic [adc_capture_pkg::NUM_ADC-1:0] o_adc_data,
  output adc_capture_pkg::samples_type o_sent,
  output int o_rise_cnt,
  output int o_lead_ns,
  output int o_tail_ns,
  output int o_mid_cnt,
  output int o_period_ns
);
  adc_capture_pkg::samples_type conv_word;
  adc_capture_pkg::samples_type shift_word;
  realtime cnv_t;
  realtime burst_cnv_t;
  realtime first_rise_t;
  int rises;
  int falls;
  int mid;
  int lead;

  initial begin
    o_adc_data = 4'h0;
    o_sent = '0;
    rises = 0;
    falls = 0;
  end

  // convert rise starts a conversion; result is ready, msb on the line, 120 ns later
  always @(posedge i_convert_pulse) begin
    conv_word = i_words;
    cnv_t = $realtime;
    mid = rises;
    #120;
    shift_word = conv_word;
    burst_cnv_t = cnv_t;
    rises = 0;
    falls = 0;
    for (int c = 0; c < adc_capture_pkg::NUM_ADC; c++) begin
      o_adc_data[c] = shift_word.word[c][adc_capture_pkg::WORD_W-1];
    end
  end

  // measure lead time and bit clock period
  always @(posedge i_bit_clk) begin
    rises = rises + 1;
    if (rises == 1) begin
      first_rise_t = $realtime;
      lead = $rtoi($realtime - burst_cnv_t);
    end
    if (rises == 2) begin
      o_period_ns = $rtoi($realtime - first_rise_t);
    end
  end

  // next bit on each falling edge; afterwards the line shows the inverse of the last bit
  always @(negedge i_bit_clk) begin
    falls = falls + 1;
    if (falls < adc_capture_pkg::WORD_W) begin
      for (int c = 0; c < adc_capture_pkg::NUM_ADC; c++) begin
        o_adc_data[c] = shift_word.word[c][adc_capture_pkg::WORD_W-1-falls];
      end
    end else begin
      o_adc_data = ~o_adc_data;
    end
    if (falls >= adc_capture_pkg::WORD_W) begin
      o_sent = shift_word;
      o_rise_cnt = rises;
      o_lead_ns = lead;
      o_tail_ns = $rtoi($realtime - cnv_t);
      o_mid_cnt = mid;
    end
  end
endmodule // adc_chip_model

// >>> bench/adc_serial_capture_tb.sv
// self-checking testbench of the four-channel serial converter capture block
`timescale 1ns/100ps
`define CHECK(act, exp, msg) begin \
  check_count++; \
  if ((act) !== (exp)) begin \
    errors++; \
    $display("CHECK FAILED at %0t: %s", $time, msg); \
  end \
end
module adc_serial_capture_tb;
  logic i_clk;
  logic i_reset_n;
  logic i_pll_clk;
  logic [adc_capture_pkg::NUM_ADC-1:0] adc_data;
  logic o_convert_pulse;
  logic o_bit_clk;
  logic o_new_data;
  adc_capture_pkg::samples_type o_samples;
  adc_capture_pkg::samples_type words;
  adc_capture_pkg::samples_type sent;
  int rise_cnt;
  int lead_ns;
  int tail_ns;
  int mid_cnt;
  int period_ns;
  int errors = 0;
  int check_count = 0;
  int frame = 0;
  int cyc_cnv = 0;
  int cyc_stb = 0;
  bit cnv_seen;
  bit stb_seen;
  logic prev_cnv;
  logic prev_stb;
  logic [adc_capture_pkg::WORD_W-1:0] corner [6] = '{16'h0000, 16'hffff, 16'h8000,
    16'h0001, 16'haaaa, 16'h5555};

  adc_serial_capture i_adc_serial_capture (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_pll_clk(i_pll_clk), .i_adc_data(adc_data),
    .o_convert_pulse(o_convert_pulse), .o_bit_clk(o_bit_clk), .o_new_data(o_new_data),
    .o_samples(o_samples)
  );

  adc_chip_model i_adc_chip_model (
    .i_convert_pulse(o_convert_pulse), .i_bit_clk(o_bit_clk), .i_words(words),
    .o_adc_data(adc_data), .o_sent(sent), .o_rise_cnt(rise_cnt), .o_lead_ns(lead_ns),
    .o_tail_ns(tail_ns), .o_mid_cnt(mid_cnt), .o_period_ns(period_ns)
  );

  // logic clock, and the bit clock source at twice its rate
  // pll rises 7.7 ns after each logic edge; the 145 ns lead needs at least 5 ns there
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    i_pll_clk = 1'b0;
    #2.7;
    forever #5 i_pll_clk = ~i_pll_clk;
  end

  // corner words first, then random words
  function automatic adc_capture_pkg::samples_type next_words();
    adc_capture_pkg::samples_type w;
    for (int c = 0; c < adc_capture_pkg::NUM_ADC; c++) begin
      if (frame < 6) w.word[c] = corner[(frame + c) % 6];
      else w.word[c] = 16'($urandom);
    end
    frame++;
    return w;
  endfunction

  // new analog values once each convert pulse has been seen
  task automatic run_frames(input int n);
    repeat (n) begin
      @(posedge o_convert_pulse);
      repeat (3) @(posedge i_clk);
      #1 words = next_words();
    end
  endtask

  // everything that must hold when the new-data strobe fires
  task automatic check_strobe();
    `CHECK(cyc_stb, adc_capture_pkg::FRAME_CYC, "strobe spacing")
    for (int c = 0; c < adc_capture_pkg::NUM_ADC; c++) begin
      `CHECK(o_samples.word[c], sent.word[c], "sample word")
    end
    `CHECK(rise_cnt, adc_capture_pkg::WORD_W, "bit clocks per burst")
    `CHECK(period_ns, 10, "bit clock period")
    `CHECK(lead_ns >= 145, 1'b1, "convert to first bit clock")
    `CHECK(tail_ns <= 110, 1'b1, "last bit clock fall late")
    `CHECK(mid_cnt > 0 && mid_cnt < 16, 1'b1, "convert not mid burst")
    `CHECK(o_bit_clk, 1'b0, "strobe during burst")
  endtask

  // monitor convert pulse and strobe timing a little after each logic edge
  always @(posedge i_clk) begin
    #2;
    if (i_reset_n === 1'b0) begin
      cnv_seen = 1'b0;
      stb_seen = 1'b0;
      prev_cnv = 1'b0;
      prev_stb = 1'b0;
    end else begin
      cyc_cnv++;
      cyc_stb++;
      if (o_convert_pulse === 1'b1 && prev_cnv === 1'b0) begin
        if (cnv_seen) `CHECK(cyc_cnv, adc_capture_pkg::FRAME_CYC, "convert period")
        cnv_seen = 1'b1;
        cyc_cnv = 0;
      end
      if (o_convert_pulse === 1'b0 && prev_cnv === 1'b1)
        `CHECK(cyc_cnv, adc_capture_pkg::CNV_HIGH_CYC, "convert width")
      if (prev_stb === 1'b1) `CHECK(o_new_data, 1'b0, "strobe width")
      else if (o_new_data === 1'b1) begin
        if (stb_seen) check_strobe();
        stb_seen = 1'b1;
        cyc_stb = 0;
      end
      prev_cnv = o_convert_pulse;
      prev_stb = o_new_data;
    end
  end

  // print counts and verdict, then end the run
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // cut a hang short well past the expected run time
  initial begin
    #100000;
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end

  // reset, free-run, reset again three logic cycles after a late bit clock rise, as the next gate opens and before its burst, free-run
  initial begin
    i_reset_n = 1'b0;
    words = '0;
    void'($urandom(22));
    repeat (16) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    run_frames(30);
    @(posedge o_bit_clk);
    repeat (3) @(posedge i_clk);
    #1 i_reset_n = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    `CHECK({o_convert_pulse, o_bit_clk, o_new_data, o_samples}, 67'h0, "outputs in reset")
    @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    run_frames(20);
    repeat (20) @(posedge i_clk);
    stop_test();
  end
endmodule // adc_serial_capture_tb
